// ### sarsc_top.sv
// Average-rate serial unit with smart card mode and APB registers
// What this block does
// - Code 000 clocks from external pin; code 100 is reserved, no rate.
// - Code 001 gives 115.152 kbps at 10.667 MHz, base sixteen times.
// - Code 010 gives 460.606 kbps at 10.667 MHz, base eight times.
// - Code 011 gives 720 kbps at 32 MHz, base sixteen times.
// - Code 101 gives 115.196 kbps at 16 MHz, base sixteen times.
// - Code 110 gives 460.784 kbps at 16 MHz, base sixteen times.
// - Code 111 gives 720 kbps at 16 MHz, base eight times.
// - Rate field applies only with high clock select and async mode.
// - A selected rate code other than 000 sets the base multiple, overriding its bit.
// - Rate field is writable only while transmit and receive are off.
// - A register bit switches between normal and smart card operation.
// - Smart card mode shares one pulled-up line for both directions.
// - In smart card mode with both enables on, the unit hears its own transmission.
// - In smart card mode the clock pin drives the card clock.
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps

// Two-entry buffer between receiver and register read port
module sarsc_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0] cnt, next_cnt;
  logic do_wr, do_rd;

  // Pointer and fill count update
  always_comb begin
    do_wr = in_valid & in_ready;
    do_rd = out_valid & out_ready;
    next_wp = wp;
    next_rp = rp;
    if (do_wr) next_wp = (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
    if (do_rd) next_rp = (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
    next_cnt = cnt + (AW + 1)'(do_wr) - (AW + 1)'(do_rd);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
  end

  // Storage needs no reset; empty flag guards the output
  always_ff @(posedge clk) begin
    if (do_wr) mem[wp] <= in_data;
  end

  assign in_ready = cnt != (AW + 1)'(DEPTH);
  assign out_valid = cnt != '0;
  assign out_data = mem[rp];
endmodule : sarsc_buf

module sarsc_top
  import sarsc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins; txd is open drain in smart card mode
  output logic txd_o,
  output logic txd_oe,
  input wire logic rxd_i,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe
);
  sarsc_ctrl_t ctrl, next_ctrl;
  sarsc_tx_t tx_st, next_tx_st;
  sarsc_rx_t rx_st, next_rx_st;
  logic [2:0] avg, next_avg;
  logic [15:0] div, next_div, dcnt, next_dcnt, acc, next_acc;
  logic [16:0] acc_sum;
  logic [1:0] pin_s1, pin_s2;
  logic ext_d, tick, x8, avg_on, next_sck;
  logic ovr, perr, cerr, next_ovr, next_perr, next_cerr;
  logic ovr_set, perr_set, cerr_set;
  logic [31:0] next_prdata;
  logic [11:0] tx_sh, next_tx_sh;
  logic [3:0] tx_bit, next_tx_bit, tx_os, next_tx_os;
  logic [3:0] rx_bit, next_rx_bit, rx_os, next_rx_os;
  logic [9:0] rx_sh, next_rx_sh;
  logic [3:0] os_last, os_half;
  logic rx_line, tx_level, err_drive, rx_push, buf_ready, buf_valid;
  logic [7:0] buf_data;
  logic wr, rd, setup, hit, tx_go, pop;

  // APB decode; zero wait states
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign setup = psel & ~penable;
  assign hit = paddr inside {ADDR_CTRL, ADDR_AVG, ADDR_DIV, ADDR_TXD,
                             ADDR_RXD, ADDR_STAT};
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign pop = rd & (paddr == ADDR_RXD) & buf_valid;
  assign tx_go = wr & (paddr == ADDR_TXD) & ctrl.tx_on & (tx_st == TX_IDLE);

  // Register writes and sticky flags; a set beats a same-cycle clear
  always_comb begin
    next_ctrl = ctrl;
    next_avg = avg;
    next_div = div;
    if (wr && paddr == ADDR_CTRL) next_ctrl = sarsc_ctrl_t'(pwdata[5:0]);
    if (wr && paddr == ADDR_AVG && !ctrl.tx_on && !ctrl.rx_on)
      next_avg = pwdata[2:0];
    if (wr && paddr == ADDR_DIV) next_div = pwdata[15:0];
    next_ovr = ovr_set | (ovr & ~(wr && paddr == ADDR_STAT && pwdata[ST_OVR]));
    next_perr = perr_set
              | (perr & ~(wr && paddr == ADDR_STAT && pwdata[ST_PERR]));
    next_cerr = cerr_set
              | (cerr & ~(wr && paddr == ADDR_STAT && pwdata[ST_CERR]));
    // Read data is captured in the setup phase
    next_prdata = prdata;
    if (setup) begin
      next_prdata = 32'h0;
      case (paddr)
        ADDR_CTRL: next_prdata[5:0] = ctrl;
        ADDR_AVG: next_prdata[2:0] = avg;
        ADDR_DIV: next_prdata[15:0] = div;
        ADDR_RXD: next_prdata[7:0] = buf_valid ? buf_data : 8'h00;
        ADDR_STAT: begin
          next_prdata[ST_TX_BUSY] = tx_st == TX_RUN;
          next_prdata[ST_RX_AVAIL] = buf_valid;
          next_prdata[ST_OVR] = ovr;
          next_prdata[ST_PERR] = perr;
          next_prdata[ST_CERR] = cerr;
          next_prdata[ST_AVG_ON] = avg_on;
        end
        default: next_prdata = 32'h0;
      endcase
    end
  end

  // Base clock source selection
  assign avg_on = ctrl.clock_source_hi_sel & ~ctrl.sync_mode;
  always_comb begin
    acc_sum = 17'h0;
    next_acc = acc;
    next_dcnt = dcnt;
    tick = 1'b0;
    if (avg_on) begin
      case (avg)
        AVG_EXT: tick = pin_s2[1] & ~ext_d;
        AVG_RSVD: tick = 1'b0;
        3'h1: acc_sum = {1'b0, acc} + {1'b0, INC_001};
        3'h2: acc_sum = {1'b0, acc} + {1'b0, INC_010};
        3'h3: acc_sum = {1'b0, acc} + {1'b0, INC_011};
        3'h5: acc_sum = {1'b0, acc} + {1'b0, INC_101};
        3'h6: acc_sum = {1'b0, acc} + {1'b0, INC_110};
        default: acc_sum = {1'b0, acc} + {1'b0, INC_111};
      endcase
      if (avg != AVG_EXT && avg != AVG_RSVD) begin
        next_acc = acc_sum[15:0];
        tick = acc_sum[16];
      end
    end else begin
      // Plain divider when the rate field is ignored
      next_dcnt = (dcnt == 16'h0) ? div : dcnt - 16'h1;
      tick = dcnt == 16'h0;
    end
    // Rate codes other than 000 fix the multiple, the select bit only otherwise
    x8 = (avg_on && avg != AVG_EXT) ? AVG_X8[avg]
                                    : ctrl.base_clock_multiple_sel;
    os_last = x8 ? 4'h7 : 4'hf;
    os_half = x8 ? 4'h3 : 4'h7;
    // Card clock is the base clock halved
    next_sck = (ctrl.sc_mode && tick) ? ~sck_o : sck_o;
  end

  // Transmitter: start, 8 data, then stop or parity plus two guard bits
  always_comb begin
    next_tx_st = tx_st;
    next_tx_sh = tx_sh;
    next_tx_bit = tx_bit;
    next_tx_os = tx_os;
    cerr_set = 1'b0;
    case (tx_st)
      TX_IDLE: begin
        if (tx_go) begin
          next_tx_sh = {2'b11, ctrl.sc_mode ? ^pwdata[7:0] : 1'b1,
                        pwdata[7:0], 1'b0};
          next_tx_bit = 4'h0;
          next_tx_os = 4'h0;
          next_tx_st = TX_RUN;
        end
      end
      TX_RUN: begin
        if (tick) begin
          next_tx_os = tx_os + 4'h1;
          // Sample late in the first guard bit, inside the card's error
          // pulse; a mid-bit sample would run ahead of that pulse
          if (ctrl.sc_mode && tx_bit == 4'ha && tx_os == os_last && !rx_line)
            cerr_set = 1'b1;
          if (tx_os == os_last) begin
            next_tx_os = 4'h0;
            next_tx_sh = {1'b1, tx_sh[11:1]};
            next_tx_bit = tx_bit + 4'h1;
            if (tx_bit == (ctrl.sc_mode ? 4'hb : 4'h9)) next_tx_st = TX_IDLE;
          end
        end
      end
      default: next_tx_st = TX_IDLE;
    endcase
  end

  // Line drive: push-pull normally, open drain on the shared line
  assign tx_level = (tx_st == TX_RUN) ? tx_sh[0] : 1'b1;
  always_comb begin
    if (ctrl.sc_mode) begin
      txd_o = 1'b0;
      txd_oe = ~tx_level | err_drive;
      // Own drive is heard even with no card fitted
      rx_line = pin_s2[0] & ~txd_oe;
    end else begin
      txd_o = tx_level;
      txd_oe = 1'b1;
      rx_line = pin_s2[0];
    end
  end
  assign sck_oe = ctrl.sc_mode;

  // Receiver: samples mid-bit, flags parity errors on the line
  assign err_drive = (rx_st == RX_ERR) & (rx_bit[0] ^ (rx_os > os_half));
  always_comb begin
    next_rx_st = rx_st;
    next_rx_sh = rx_sh;
    next_rx_bit = rx_bit;
    next_rx_os = rx_os;
    rx_push = 1'b0;
    perr_set = 1'b0;
    case (rx_st)
      RX_IDLE: begin
        if (ctrl.rx_on && tick && !rx_line) begin
          next_rx_bit = 4'h0;
          next_rx_os = 4'h1;
          next_rx_st = RX_RUN;
        end
      end
      RX_RUN: begin
        if (tick) begin
          next_rx_os = (rx_os == os_last) ? 4'h0 : rx_os + 4'h1;
          if (rx_os == os_last) next_rx_bit = rx_bit + 4'h1;
          if (rx_os == os_half) begin
            next_rx_sh = {rx_line, rx_sh[9:1]};
            if (rx_bit == 4'h0 && rx_line) next_rx_st = RX_IDLE;
            if (rx_bit == 4'h9) begin
              // Parity covers data and parity bit together
              if (ctrl.sc_mode && (^rx_sh[9:2] ^ rx_line)) begin
                perr_set = 1'b1;
                next_rx_st = RX_ERR;
              end else begin
                rx_push = 1'b1;
                next_rx_st = RX_IDLE;
              end
            end
          end
        end
      end
      RX_ERR: begin
        // Low from 10.5 to 11.5 bit times after the start edge
        if (tick) begin
          next_rx_os = (rx_os == os_last) ? 4'h0 : rx_os + 4'h1;
          if (rx_os == os_last) next_rx_bit = rx_bit + 4'h1;
          if (rx_bit == 4'ha + 4'h1 && rx_os == os_half) next_rx_st = RX_IDLE;
        end
      end
      default: next_rx_st = RX_IDLE;
    endcase
    // Full buffer drops the word rather than stall the line
    ovr_set = rx_push & ~buf_ready;
  end

  // Data sits just above the start bit in both framings
  sarsc_buf #(.W(8), .DEPTH(2)) u_rxbuf (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(rx_push),
    .in_ready(buf_ready),
    .in_data(rx_sh[9:2]),
    .out_valid(buf_valid),
    .out_ready(pop),
    .out_data(buf_data)
  );

  // Pin synchronisers; stage one feeds only stage two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 2'h3;
      pin_s2 <= 2'h3;
    end else begin
      pin_s1 <= {sck_i, rxd_i};
      pin_s2 <= pin_s1;
    end
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
      avg <= AVG_RST;
      div <= DIV_RST;
      dcnt <= 16'h0;
      acc <= 16'h0;
      ext_d <= 1'b1;
      sck_o <= 1'b0;
      ovr <= 1'b0;
      perr <= 1'b0;
      cerr <= 1'b0;
      prdata <= 32'h0;
      tx_st <= TX_IDLE;
      tx_sh <= 12'hfff;
      tx_bit <= 4'h0;
      tx_os <= 4'h0;
      rx_st <= RX_IDLE;
      rx_sh <= 10'h0;
      rx_bit <= 4'h0;
      rx_os <= 4'h0;
    end else begin
      ctrl <= next_ctrl;
      avg <= next_avg;
      div <= next_div;
      dcnt <= next_dcnt;
      acc <= next_acc;
      ext_d <= pin_s2[1];
      sck_o <= next_sck;
      ovr <= next_ovr;
      perr <= next_perr;
      cerr <= next_cerr;
      prdata <= next_prdata;
      tx_st <= next_tx_st;
      tx_sh <= next_tx_sh;
      tx_bit <= next_tx_bit;
      tx_os <= next_tx_os;
      rx_st <= next_rx_st;
      rx_sh <= next_rx_sh;
      rx_bit <= next_rx_bit;
      rx_os <= next_rx_os;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_avg_wr_busy;
    wr && paddr == ADDR_AVG && (ctrl.tx_on || ctrl.rx_on);
  endsequence
  chk_avg_write_lock: assert property (
    s_avg_wr_busy |=> $stable(avg))
    else $error("rate field changed while enabled");
  chk_field_ignored: assert property (!avg_on |=> $stable(acc))
    else $error("accumulator moved with rate field ignored");
  chk_reserved_quiet: assert property (
    avg_on && avg == AVG_RSVD |-> !tick)
    else $error("reserved code produced a tick");
  chk_ext_edge: assert property (avg_on && avg == AVG_EXT
    |-> tick == (pin_s2[1] && !$past(pin_s2[1])))
    else $error("external clock edge not followed");
  chk_rate_step: assert property (avg_on && avg == 3'h3
    |=> acc == 16'($past(acc) + INC_011))
    else $error("rate step for 720 kbps wrong");
  chk_auto_mult: assert property (avg_on && avg inside {3'h2, 3'h7}
    |-> os_last == 4'h7)
    else $error("eight-times base not forced");
  chk_sixteen_mult: assert property (
    avg_on && avg inside {3'h1, 3'h5} |-> os_last == 4'hf)
    else $error("sixteen-times base not forced");
  chk_open_drain: assert property (ctrl.sc_mode |-> !txd_o
    && (txd_oe == (!tx_level || err_drive)))
    else $error("shared line not open drain");
  chk_loopback: assert property (
    ctrl.sc_mode && txd_oe |-> !rx_line)
    else $error("own drive not heard");
  chk_card_clock: assert property (ctrl.sc_mode && tick
    |=> sck_o != $past(sck_o))
    else $error("card clock did not toggle");
endmodule : sarsc_top

// ### sarsc_pkg.sv
// Constants and carrier types for the average-rate serial unit
package sarsc_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_AVG = 8'h04;
  localparam logic [7:0] ADDR_DIV = 8'h08;
  localparam logic [7:0] ADDR_TXD = 8'h0c;
  localparam logic [7:0] ADDR_RXD = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;

  // Status bit positions; flags at 2..4 are write-one-to-clear
  localparam int ST_TX_BUSY = 0;
  localparam int ST_RX_AVAIL = 1;
  localparam int ST_OVR = 2;
  localparam int ST_PERR = 3;
  localparam int ST_CERR = 4;
  localparam int ST_AVG_ON = 5;

  // Control word, LSB first: tx_on, rx_on, hi_sel, sync, x8, smart card
  typedef struct packed {
    logic sc_mode;
    logic base_clock_multiple_sel;
    logic sync_mode;
    logic clock_source_hi_sel;
    logic rx_on;
    logic tx_on;
  } sarsc_ctrl_t;

  // Reset values
  localparam sarsc_ctrl_t CTRL_RST = 6'h00;
  localparam logic [2:0] AVG_RST = 3'h0;
  localparam logic [15:0] DIV_RST = 16'h000c;

  // Average rate codes with special meaning
  localparam logic [2:0] AVG_EXT = 3'h0;
  localparam logic [2:0] AVG_RSVD = 3'h4;

  // Rates in bit/s and the system clocks they are tuned for, in Hz
  localparam longint BPS_001 = 115152;
  localparam longint BPS_010 = 460606;
  localparam longint BPS_011 = 720000;
  localparam longint BPS_101 = 115196;
  localparam longint BPS_110 = 460784;
  localparam longint BPS_111 = 720000;
  localparam longint FSYS_A = 10667000;
  localparam longint FSYS_B = 32000000;
  localparam longint FSYS_C = 16000000;
  localparam longint ACC_ONE = 65536;

  // Phase step per system clock so that ticks run at mult * rate
  function automatic logic [15:0] sarsc_step(longint bps, longint mul,
                                             longint fhz);
    return 16'((bps * mul * ACC_ONE + fhz / 2) / fhz);
  endfunction : sarsc_step

  localparam logic [15:0] INC_001 = sarsc_step(BPS_001, 16, FSYS_A);
  localparam logic [15:0] INC_010 = sarsc_step(BPS_010, 8, FSYS_A);
  localparam logic [15:0] INC_011 = sarsc_step(BPS_011, 16, FSYS_B);
  localparam logic [15:0] INC_101 = sarsc_step(BPS_101, 16, FSYS_C);
  localparam logic [15:0] INC_110 = sarsc_step(BPS_110, 16, FSYS_C);
  localparam logic [15:0] INC_111 = sarsc_step(BPS_111, 8, FSYS_C);
  // Codes whose base clock is eight times the bit rate
  localparam logic [7:0] AVG_X8 = 8'h84;

  // Transmit and receive sequencer states
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_RUN = 2'b10} sarsc_tx_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_RUN = 3'b010,
    RX_ERR = 3'b100
  } sarsc_rx_t;

endpackage : sarsc_pkg

// ### sarsc_peer.sv
// Far-side serial peer: shared line, frame sender and frame decoder
`timescale 1ns/10ps
module sarsc_peer (
  // Clock
  input wire logic pclk,
  // Unit pins; no card reset here, a general port owns it
  input wire logic txd_o,
  input wire logic txd_oe,
  input wire logic sc_mode,
  // Level fed to the unit's receive input
  output logic rxd
);
  logic drv_low = 1'b0;
  logic tx_lvl = 1'b1;
  logic line;
  logic obs;
  // Pull-up wins unless somebody sinks the shared line
  assign line = !((txd_oe && !txd_o) || drv_low);
  assign rxd = sc_mode ? line : tx_lvl;
  // What a listener on the wire sees
  assign obs = sc_mode ? line : txd_o;

  // One frame, then an idle bit; card frames carry even parity
  task automatic send(input logic [7:0] b, input int bc, input logic bad);
    logic [10:0] f;
    f = sc_mode ? {1'b1, ^b ^ bad, b, 1'b0} : {2'b11, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      tx_lvl <= f[i];
      drv_low <= sc_mode & !f[i];
      repeat (bc) @(posedge pclk);
    end
  endtask : send

  // Bounded wait for a start edge
  task automatic wait_low;
    for (int n = 0; n < 20000 && obs !== 1'b0; n++) @(negedge pclk);
  endtask : wait_low

  // Sample data and parity at mid bit
  task automatic recv(input int bc, output logic [8:0] d);
    wait_low();
    repeat (bc / 2) @(negedge pclk);
    for (int i = 0; i < 9; i++) begin
      repeat (bc) @(negedge pclk);
      d[i] = obs;
    end
  endtask : recv

  // Card refusing a character: low from 10.5 to 11.5 bit times
  task automatic nack(input int bc);
    wait_low();
    repeat (10 * bc + bc / 2) @(posedge pclk);
    drv_low <= 1'b1;
    repeat (bc) @(posedge pclk);
    drv_low <= 1'b0;
  endtask : nack

  // Length of the first low stretch, in cycles
  task automatic low_len(output int len);
    len = 0;
    wait_low();
    while (obs === 1'b0 && len < 20000) begin
      @(negedge pclk);
      len++;
    end
  endtask : low_len
endmodule : sarsc_peer

// ### tb.sv
// Self-checking bench for the average-rate serial unit
`timescale 1ns/10ps
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
module tb;
  import sarsc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, txd_o, txd_oe, rxd_i, sck_o, sck_oe, last_sck;
  logic sck_i = 1'b0;
  logic sck_run = 1'b0;
  logic [2:0] sck_div = 3'h0;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int oe_hi = 0;
  int sck_edges = 0;

  sarsc_top sarsc_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd_o(txd_o),
    .txd_oe(txd_oe), .rxd_i(rxd_i), .sck_i(sck_i), .sck_o(sck_o),
    .sck_oe(sck_oe));
  sarsc_peer sarsc_peer_i (.pclk(pclk), .txd_o(txd_o), .txd_oe(txd_oe),
    .sc_mode(sck_oe), .rxd(rxd_i));

  // 200 MHz system clock
  initial begin
    forever #2.5 pclk = ~pclk;
  end

  // External base clock, pin watchers and the hang limit
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    sck_div <= sck_div + 3'h1;
    sck_i <= sck_run & sck_div[2];
    last_sck <= sck_o;
    if (sck_o !== last_sck) sck_edges <= sck_edges + 1;
    if (sck_oe === 1'b1 && txd_oe === 1'b1) begin
      oe_hi <= oe_hi + 1;
      `CHK(txd_o, 1'b0)
    end
    if (cyc == 60000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  // One APB transfer; entered and left just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask : do_reset

  task automatic wait_idle;
    logic [31:0] q = 32'h1;
    for (int i = 0; i < 3000 && q[ST_TX_BUSY] !== 1'b0; i++) begin
      rd(ADDR_STAT, q);
    end
  endtask : wait_idle

  // Send 0x00 and time start plus eight zero bits on the line
  task automatic tx_len(input logic [2:0] code, input logic [5:0] ctrl,
                        input longint exp);
    int len;
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_AVG, {29'h0, code});
    wr(ADDR_DIV, 32'h1);
    wr(ADDR_CTRL, {26'h0, ctrl});
    wr(ADDR_TXD, 32'h0);
    sarsc_peer_i.low_len(len);
    `CHK(len >= exp - exp / 32 - 8 && len <= exp + exp / 32 + 8, 1'b1)
    wait_idle();
  endtask : tx_len

  task automatic t_regs;
    logic [31:0] q;
    logic e;
    rd(ADDR_CTRL, q);
    `CHK(q, 32'h0)
    rd(ADDR_AVG, q);
    `CHK(q, 32'h0)
    rd(ADDR_DIV, q);
    `CHK(q, 32'h0000000c)
    apb(1'b0, 8'h18, 32'h0, q, e);
    `CHK({e, q}, 33'h100000000)
    wr(ADDR_AVG, 32'h5);
    for (int i = 1; i < 4; i++) begin
      wr(ADDR_CTRL, 32'(i));
      wr(ADDR_AVG, 32'h3);
      rd(ADDR_AVG, q);
      `CHK(q, 32'h5)
    end
    wr(ADDR_CTRL, 32'h4);
    rd(ADDR_STAT, q);
    `CHK(q[ST_AVG_ON], 1'b1)
    wr(ADDR_CTRL, 32'hc);
    rd(ADDR_STAT, q);
    `CHK(q[ST_AVG_ON], 1'b0)
    $display("t_regs finished");
  endtask : t_regs

  // Multiple bit set opposite to the code's own, to see the override
  // Bit times are in cycles of the tuned clock, since each step assumes pclk runs at it
  task automatic t_rates;
    logic [31:0] q;
    tx_len(3'h1, 6'h15, 9 * FSYS_A / BPS_001);
    tx_len(3'h2, 6'h05, 9 * FSYS_A / BPS_010);
    tx_len(3'h3, 6'h15, 9 * FSYS_B / BPS_011);
    tx_len(3'h5, 6'h15, 9 * FSYS_C / BPS_101);
    tx_len(3'h6, 6'h15, 9 * FSYS_C / BPS_110);
    tx_len(3'h7, 6'h05, 9 * FSYS_C / BPS_111);
    tx_len(3'h1, 6'h01, 288);
    tx_len(3'h1, 6'h0d, 288);
    sck_run <= 1'b1;
    tx_len(3'h0, 6'h05, 1152);
    sck_run <= 1'b0;
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_AVG, 32'h4);
    wr(ADDR_CTRL, 32'h5);
    wr(ADDR_TXD, 32'h0);
    repeat (2000) @(posedge pclk);
    rd(ADDR_STAT, q);
    `CHK(q[ST_TX_BUSY], 1'b1)
    do_reset();
    $display("t_rates finished");
  endtask : t_rates

  task automatic t_card;
    logic [8:0] d;
    logic [31:0] q;
    int e0;
    wr(ADDR_DIV, 32'h1);
    wr(ADDR_CTRL, 32'h23);
    `CHK(sck_oe, 1'b1)
    e0 = sck_edges;
    fork
      wr(ADDR_TXD, 32'ha7);
      sarsc_peer_i.recv(32, d);
    join
    `CHK(d, 9'h1a7)
    `CHK(sck_edges > e0 + 8, 1'b1)
    wait_idle();
    rd(ADDR_RXD, q);
    `CHK(q, 32'ha7)
    rd(ADDR_STAT, q);
    `CHK(q[ST_CERR], 1'b0)
    // Receive only, so any drive now is the error pulse
    wr(ADDR_CTRL, 32'h22);
    e0 = oe_hi;
    sarsc_peer_i.send(8'h3c, 32, 1'b1);
    repeat (64) @(posedge pclk);
    `CHK(oe_hi - e0 >= 16 && oe_hi - e0 <= 40, 1'b1)
    rd(ADDR_STAT, q);
    `CHK(q[ST_PERR], 1'b1)
    wr(ADDR_STAT, 32'h1 << ST_PERR);
    rd(ADDR_STAT, q);
    `CHK(q[ST_PERR], 1'b0)
    // Transmit only; the peer refuses the character in the guard time
    wr(ADDR_CTRL, 32'h21);
    fork
      wr(ADDR_TXD, 32'h5a);
      sarsc_peer_i.nack(32);
    join
    wait_idle();
    rd(ADDR_STAT, q);
    `CHK(q[ST_CERR], 1'b1)
    wr(ADDR_STAT, 32'h1 << ST_CERR);
    rd(ADDR_STAT, q);
    `CHK(q[ST_CERR], 1'b0)
    $display("t_card finished");
  endtask : t_card

  // Three words into a two-entry buffer that nobody drains
  task automatic t_buf;
    logic [31:0] q;
    do_reset();
    wr(ADDR_DIV, 32'h1);
    wr(ADDR_CTRL, 32'h2);
    for (int i = 1; i < 4; i++) sarsc_peer_i.send(8'(i * 17), 32, 1'b0);
    rd(ADDR_STAT, q);
    `CHK(q[ST_OVR], 1'b1)
    for (int i = 1; i < 4; i++) begin
      rd(ADDR_RXD, q);
      `CHK(q, (i < 3) ? 32'(i * 17) : 32'h0)
    end
    rd(ADDR_STAT, q);
    `CHK(q[ST_RX_AVAIL], 1'b0)
    $display("t_buf finished");
  endtask : t_buf

  initial begin
    do_reset();
    t_regs();
    t_rates();
    t_card();
    t_buf();
    give_verdict();
  end
endmodule : tb
